// file: src/gsct_cache_slot.sv
// gsct_cache_slot: one cached control block identity, held as the block's physical address.
// assumes the parent allocates at most one slot per cycle.
`timescale 1ns/100ps
module gsct_cache_slot (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      alloc_en,
  input  wire logic [gsct_pkg::CBA_W-1:0] alloc_addr,
  input  wire logic [gsct_pkg::CBA_W-1:0] cmp_addr,
  output logic                           match
);
  logic                       valid_r;
  logic [gsct_pkg::CBA_W-1:0] addr_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      valid_r <= 1'b0;
      addr_r  <= '0;
    end else if (alloc_en) begin
      valid_r <= 1'b1;
      addr_r  <= alloc_addr;
    end
  end

  assign match = valid_r && (addr_r == cmp_addr);
endmodule // gsct_cache_slot

// file: src/gsct_pkg.sv
// gsct_pkg: constants, state codes and carrier structs for the guest state cache and tlb flush block.
// assumes one core clock; every user writes gsct_pkg::name, nothing is imported.
package gsct_pkg;
  localparam int TAG_W  = 12;
  localparam int VPN_W  = 36;
  localparam int PPN_W  = 40;
  localparam int CBA_W  = 52;
  localparam int MASK_W = 32;
  localparam int GRP_W  = 12;
  localparam int FCMD_W = 8;
  localparam int ACC_W  = 64;
  localparam int CNT_W  = 32;
  localparam int PG_SH  = 12;
  localparam int TLB_N  = 16;
  localparam int TLB_IW = 4;
  localparam int SLOT_N = 4;
  localparam int SLOT_IW = 2;

  // flush command byte encodings
  localparam logic [FCMD_W-1:0] FCMD_NONE   = 8'h00;
  localparam logic [FCMD_W-1:0] FCMD_ALL    = 8'h01;
  localparam logic [FCMD_W-1:0] FCMD_TAG    = 8'h03;
  localparam logic [FCMD_W-1:0] FCMD_TAG_NG = 8'h07;

  localparam logic [TAG_W-1:0] TAG_HOST = 12'h000;
  // per-tag flush capability flag as seen by software
  localparam logic CAP_FLUSH_BY_TAG = 1'h1;

  typedef enum logic [1:0] {
    ST_HOST  = 2'b00,
    ST_CHECK = 2'b01,
    ST_FLUSH = 2'b10,
    ST_GUEST = 2'b11
  } gsct_state_e;

  typedef struct packed {
    logic [CBA_W-1:0]  cb_addr;
    logic [MASK_W-1:0] reload_mask;
    logic [FCMD_W-1:0] flush_cmd;
    logic [TAG_W-1:0]  tag;
  } gsct_entry_s;

  typedef struct packed {
    logic intercepted;
    logic pt_base_wr;
    logic task_pt_chg;
    logic pg_toggle;
    logic cr4_pg_chg;
    logic system_management_interrupt;
    logic sm_return;
    logic memory_type_range_registers_wr;
    logic io_range_registers_wr;
    logic sysreg_wr;
  } gsct_evt_s;

  typedef struct packed {
    logic [VPN_W-1:0] vpn;
    logic [PPN_W-1:0] ppn;
    logic             glob;
  } gsct_fill_s;

  typedef struct packed {
    logic             valid;
    logic             glob;
    logic [TAG_W-1:0] tag;
    logic [VPN_W-1:0] vpn;
    logic [PPN_W-1:0] ppn;
  } gsct_tlbe_s;
endpackage

// file: src/gsct_tlb_entry.sv
// gsct_tlb_entry: one tagged translation entry with its own flush and match logic.
// assumes the parent never fills an entry in a cycle that also flushes.
`timescale 1ns/100ps
module gsct_tlb_entry (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      fill_en,
  input  wire gsct_pkg::gsct_tlbe_s      fill_d,
  input  wire logic                      inval_all,
  input  wire logic                      inval_tag_en,
  input  wire logic [gsct_pkg::TAG_W-1:0] inval_tag,
  input  wire logic                      inval_glob,
  input  wire logic                      page_en,
  input  wire logic [gsct_pkg::TAG_W-1:0] page_tag,
  input  wire logic [gsct_pkg::VPN_W-1:0] page_vpn,
  input  wire logic [gsct_pkg::TAG_W-1:0] look_tag,
  input  wire logic [gsct_pkg::VPN_W-1:0] look_vpn,
  output logic                           hit,
  output logic [gsct_pkg::PPN_W-1:0]     ppn
);
  gsct_pkg::gsct_tlbe_s e_r;
  logic kill;

  // a global entry is only global within its own tag
  assign kill = inval_all
             || (inval_tag_en && e_r.tag == inval_tag && (inval_glob || !e_r.glob))
             || (page_en && e_r.tag == page_tag && e_r.vpn == page_vpn);

  always_ff @(posedge clk) begin
    if (rst) begin
      e_r <= '0;
    end else if (kill) begin
      e_r.valid <= 1'b0;
    end else if (fill_en) begin
      e_r <= fill_d;
    end
  end

  assign hit = e_r.valid && e_r.tag == look_tag && e_r.vpn == look_vpn;
  assign ppn = e_r.ppn;
endmodule // gsct_tlb_entry

// file: src/gsct_top.sv
// gsct_top: guest entry state cache selection and tagged translation buffer flush control.
// assumes hypervisor hands the control block fields on ENTRY with ENTRY_REQ, and the core
// reports flush-causing events on EVT each cycle they happen.
`timescale 1ns/100ps
module gsct_top (
  input  wire logic                      CLOCK,
  input  wire logic                      SYS_RST,
  input  wire logic                      ENTRY_REQ,
  input  wire gsct_pkg::gsct_entry_s     ENTRY,
  input  wire logic                      EXIT_REQ,
  input  wire gsct_pkg::gsct_evt_s       EVT,
  input  wire logic                      INVPG_REQ,
  input  wire logic [gsct_pkg::ACC_W-1:0] INVPG_ACC,
  input  wire logic [gsct_pkg::CNT_W-1:0] INVPG_CNT,
  input  wire logic                      FILL_REQ,
  input  wire gsct_pkg::gsct_fill_s      FILL,
  input  wire logic                      LOOKUP_REQ,
  input  wire logic [gsct_pkg::VPN_W-1:0] LOOKUP_VPN,
  output logic                           ENTRY_DONE,
  output logic                           ENTRY_BAD_CMD,
  output logic [gsct_pkg::GRP_W-1:0]     USE_CACHE,
  output logic                           UNCACHED_FETCH,
  output logic                           IN_GUEST,
  output logic [gsct_pkg::TAG_W-1:0]     CUR_TAG,
  output logic                           XLATE_READY,
  output logic                           LOOKUP_VALID,
  output logic                           LOOKUP_HIT,
  output logic [gsct_pkg::PPN_W-1:0]     LOOKUP_PPN,
  output logic                           CAP_FLUSH_TAG
);
  gsct_pkg::gsct_state_e st_r;
  gsct_pkg::gsct_state_e st_nxt;
  gsct_pkg::gsct_entry_s ent_r;

  logic                          in_guest_r;
  logic [gsct_pkg::TAG_W-1:0]    guest_tag_r;
  logic [gsct_pkg::TAG_W-1:0]    cur_tag;
  logic                          exec_ok;
  logic                          fl_all_r;
  logic                          fl_tag_r;
  logic                          fl_glob_r;
  logic                          bad_cmd_nxt;
  logic                          dec_all;
  logic                          dec_tag;
  logic                          dec_glob;
  logic [gsct_pkg::SLOT_N-1:0]   slot_match;
  logic [gsct_pkg::SLOT_N-1:0]   slot_alloc;
  logic [gsct_pkg::SLOT_IW-1:0]  slot_vict_r;
  logic                          cb_hit;
  logic                          ev_ok;
  logic                          ev_all;
  logic                          ev_tag;
  logic                          ev_glob;
  logic                          inval_all;
  logic                          inval_tag_en;
  logic [gsct_pkg::TAG_W-1:0]    inval_tag;
  logic                          inval_glob;
  logic                          page_en;
  logic [gsct_pkg::TAG_W-1:0]    page_tag;
  logic [gsct_pkg::VPN_W-1:0]    page_vpn;
  logic                          any_flush;
  logic                          fill_ok;
  logic [gsct_pkg::TLB_IW-1:0]   tlb_vict_r;
  gsct_pkg::gsct_tlbe_s          fill_d;
  logic [gsct_pkg::TLB_N-1:0]    tlb_hit;
  logic [gsct_pkg::PPN_W-1:0]    tlb_ppn [gsct_pkg::TLB_N];
  logic                          look_hit;
  logic [gsct_pkg::PPN_W-1:0]    look_ppn;

  // sequencing of one guest entry
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      gsct_pkg::ST_HOST: begin
        if (ENTRY_REQ) begin
          st_nxt = gsct_pkg::ST_CHECK;
        end
      end
      gsct_pkg::ST_CHECK: begin
        st_nxt = gsct_pkg::ST_FLUSH;
      end
      gsct_pkg::ST_FLUSH: begin
        st_nxt = gsct_pkg::ST_GUEST;
      end
      gsct_pkg::ST_GUEST: begin
        if (EXIT_REQ) begin
          st_nxt = gsct_pkg::ST_HOST;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      st_r <= gsct_pkg::ST_HOST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // the control block fields are sampled once; nothing is ever written back
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ent_r <= '0;
    end else if (st_r == gsct_pkg::ST_HOST && ENTRY_REQ) begin
      ent_r <= ENTRY;
    end
  end

  // guest context and current tag; exit loads nothing into the buffer
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      in_guest_r  <= 1'b0;
      guest_tag_r <= gsct_pkg::TAG_HOST;
    end else if (st_r == gsct_pkg::ST_FLUSH) begin
      in_guest_r  <= 1'b1;
      guest_tag_r <= ent_r.tag;
    end else if (st_r == gsct_pkg::ST_GUEST && EXIT_REQ) begin
      in_guest_r  <= 1'b0;
      guest_tag_r <= gsct_pkg::TAG_HOST;
    end
  end

  // the tag register itself falls back to the host tag, so the port comes straight off a flop
  assign cur_tag = guest_tag_r;

  // translation is shut off while the entry sequence is still checking and flushing
  assign exec_ok = (st_r == gsct_pkg::ST_HOST) || (st_r == gsct_pkg::ST_GUEST);

  // control block identity cache
  genvar gs;
  generate
    for (gs = 0; gs < gsct_pkg::SLOT_N; gs++) begin : g_slot
      assign slot_alloc[gs] = (st_r == gsct_pkg::ST_CHECK) && !cb_hit
                              && (slot_vict_r == (gsct_pkg::SLOT_IW)'(gs));
      gsct_cache_slot u_slot (
        .clk        (CLOCK),
        .rst        (SYS_RST),
        .alloc_en   (slot_alloc[gs]),
        .alloc_addr (ent_r.cb_addr),
        .cmp_addr   (ent_r.cb_addr),
        .match      (slot_match[gs])
      );
    end
  endgenerate

  assign cb_hit = |slot_match;

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      slot_vict_r <= '0;
    end else if (st_r == gsct_pkg::ST_CHECK && !cb_hit) begin
      slot_vict_r <= slot_vict_r + 1'b1;
    end
  end

  // only the twelve defined groups may come from the cache; a zero bit or a
  // miss on the block address always forces the group back from memory.
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      USE_CACHE      <= '0;
      UNCACHED_FETCH <= 1'b0;
    end else begin
      UNCACHED_FETCH <= (st_r == gsct_pkg::ST_CHECK);
      if (st_r == gsct_pkg::ST_CHECK) begin
        USE_CACHE <= cb_hit ? ent_r.reload_mask[gsct_pkg::GRP_W-1:0] : '0;
      end
    end
  end

  // flush command decode; per-tag commands only exist with the capability
  always_comb begin
    dec_all     = 1'b0;
    dec_tag     = 1'b0;
    dec_glob    = 1'b0;
    bad_cmd_nxt = 1'b0;
    if (ent_r.flush_cmd == gsct_pkg::FCMD_NONE) begin
      dec_all = 1'b0;
    end else if (ent_r.flush_cmd == gsct_pkg::FCMD_ALL) begin
      dec_all = 1'b1;
    end else if (gsct_pkg::CAP_FLUSH_BY_TAG && ent_r.flush_cmd == gsct_pkg::FCMD_TAG) begin
      dec_tag  = 1'b1;
      dec_glob = 1'b1;
    end else if (gsct_pkg::CAP_FLUSH_BY_TAG && ent_r.flush_cmd == gsct_pkg::FCMD_TAG_NG) begin
      dec_tag  = 1'b1;
    end else begin
      bad_cmd_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      fl_all_r      <= 1'b0;
      fl_tag_r      <= 1'b0;
      fl_glob_r     <= 1'b0;
      ENTRY_BAD_CMD <= 1'b0;
    end else if (st_r == gsct_pkg::ST_CHECK) begin
      fl_all_r      <= dec_all;
      fl_tag_r      <= dec_tag;
      fl_glob_r     <= dec_glob;
      ENTRY_BAD_CMD <= bad_cmd_nxt;
    end
  end

  // core events; an intercepted one becomes an exit and flushes nothing
  assign ev_ok   = exec_ok && !EVT.intercepted;
  assign ev_all  = EVT.system_management_interrupt || EVT.sm_return || EVT.memory_type_range_registers_wr || EVT.io_range_registers_wr || EVT.sysreg_wr;
  assign ev_tag  = EVT.pt_base_wr || EVT.task_pt_chg || EVT.pg_toggle || EVT.cr4_pg_chg;
  assign ev_glob = EVT.cr4_pg_chg || EVT.pg_toggle;

  assign inval_all    = (st_r == gsct_pkg::ST_FLUSH && fl_all_r) || (ev_ok && ev_all);
  assign inval_tag_en = (st_r == gsct_pkg::ST_FLUSH && fl_tag_r) || (ev_ok && ev_tag);
  assign inval_tag    = (st_r == gsct_pkg::ST_FLUSH) ? ent_r.tag : cur_tag;
  assign inval_glob   = (st_r == gsct_pkg::ST_FLUSH) ? fl_glob_r : ev_glob;

  // page invalidate: accumulator holds a guest virtual address, never a physical one
  assign page_en  = exec_ok && INVPG_REQ;
  assign page_tag = INVPG_CNT[gsct_pkg::TAG_W-1:0];
  assign page_vpn = INVPG_ACC[gsct_pkg::PG_SH +: gsct_pkg::VPN_W];

  // a refill racing a flush is dropped so a stale mapping cannot survive it
  assign any_flush = inval_all || inval_tag_en || page_en;
  assign fill_ok   = exec_ok && FILL_REQ && !any_flush;

  always_comb begin
    fill_d       = '0;
    fill_d.valid = 1'b1;
    fill_d.glob  = FILL.glob;
    fill_d.tag   = cur_tag;
    fill_d.vpn   = FILL.vpn;
    fill_d.ppn   = FILL.ppn;
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      tlb_vict_r <= '0;
    end else if (fill_ok) begin
      tlb_vict_r <= tlb_vict_r + 1'b1;
    end
  end

  genvar gt;
  generate
    for (gt = 0; gt < gsct_pkg::TLB_N; gt++) begin : g_tlb
      gsct_tlb_entry u_ent (
        .clk          (CLOCK),
        .rst          (SYS_RST),
        .fill_en      (fill_ok && tlb_vict_r == (gsct_pkg::TLB_IW)'(gt)),
        .fill_d       (fill_d),
        .inval_all    (inval_all),
        .inval_tag_en (inval_tag_en),
        .inval_tag    (inval_tag),
        .inval_glob   (inval_glob),
        .page_en      (page_en),
        .page_tag     (page_tag),
        .page_vpn     (page_vpn),
        .look_tag     (cur_tag),
        .look_vpn     (LOOKUP_VPN),
        .hit          (tlb_hit[gt]),
        .ppn          (tlb_ppn[gt])
      );
    end
  endgenerate

  always_comb begin
    look_hit = 1'b0;
    look_ppn = '0;
    for (int i = 0; i < gsct_pkg::TLB_N; i++) begin
      if (tlb_hit[i]) begin
        look_hit = 1'b1;
        look_ppn = look_ppn | tlb_ppn[i];
      end
    end
  end

  // lookups are answered one cycle later; none is taken during entry
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      LOOKUP_VALID <= 1'b0;
      LOOKUP_HIT   <= 1'b0;
      LOOKUP_PPN   <= '0;
    end else begin
      LOOKUP_VALID <= exec_ok && LOOKUP_REQ;
      LOOKUP_HIT   <= exec_ok && LOOKUP_REQ && look_hit;
      if (exec_ok && LOOKUP_REQ) begin
        LOOKUP_PPN <= look_ppn;
      end
    end
  end

  // status outputs
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ENTRY_DONE    <= 1'b0;
      XLATE_READY   <= 1'b0;
      CAP_FLUSH_TAG <= 1'b0;
    end else begin
      ENTRY_DONE    <= (st_r == gsct_pkg::ST_FLUSH);
      XLATE_READY   <= (st_nxt == gsct_pkg::ST_HOST) || (st_nxt == gsct_pkg::ST_GUEST);
      CAP_FLUSH_TAG <= gsct_pkg::CAP_FLUSH_BY_TAG;
    end
  end

  assign IN_GUEST = in_guest_r;
  assign CUR_TAG  = cur_tag;
endmodule // gsct_top

// file: verification/gsct_hv_model.sv
// gsct_hv_model: hypervisor side, composes the control block fields for one guest entry.
// assumes the bench drives its controls away from the rising clock edge.
`timescale 1ns/100ps
module gsct_hv_model (
  input  wire logic                        go,
  input  wire logic [gsct_pkg::CBA_W-1:0]  cb_addr,
  input  wire logic [gsct_pkg::TAG_W-1:0]  tag,
  input  wire logic                        fresh,
  input  wire logic [gsct_pkg::GRP_W-1:0]  changed,
  input  wire logic [gsct_pkg::FCMD_W-1:0] cmd,
  output logic                             entry_req,
  output gsct_pkg::gsct_entry_s            entry
);
  always_comb begin
    entry_req       = go;
    entry.cb_addr   = cb_addr;
    entry.tag       = tag;
    entry.flush_cmd = cmd;
    if (fresh)
      entry.reload_mask = 32'h0000_0000;
    else if (changed == 12'h000)
      entry.reload_mask = 32'hffff_ffff;
    else
      entry.reload_mask = {20'h00000, ~changed};
    // outside a request the fields are not held, so a stale sample cannot pass by luck
    if (!go)
      entry = ~entry;
  end
endmodule // gsct_hv_model

// file: verification/gsct_top_properties.sv
// gsct_top_properties: port timing checks for gsct_top, bound in at the foot of this file.
// assumes one core clock and the synchronous active-high reset of gsct_top.
`timescale 1ns/100ps
module gsct_top_properties (
  input wire logic                        CLOCK,
  input wire logic                        SYS_RST,
  input wire logic                        ENTRY_REQ,
  input wire gsct_pkg::gsct_entry_s       ENTRY,
  input wire logic                        EXIT_REQ,
  input wire logic                        LOOKUP_REQ,
  input wire logic                        ENTRY_DONE,
  input wire logic                        ENTRY_BAD_CMD,
  input wire logic [gsct_pkg::GRP_W-1:0]  USE_CACHE,
  input wire logic                        UNCACHED_FETCH,
  input wire logic                        IN_GUEST,
  input wire logic [gsct_pkg::TAG_W-1:0]  CUR_TAG,
  input wire logic                        XLATE_READY,
  input wire logic                        LOOKUP_VALID,
  input wire logic                        CAP_FLUSH_TAG
);
  wire logic entry_go;

  // an entry is only taken from an idle host context
  assign entry_go = ENTRY_REQ && !IN_GUEST && XLATE_READY;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  property p_entry_done;
    entry_go |-> ##3 (ENTRY_DONE && IN_GUEST);
  endproperty
  a_entry_done: assert property (p_entry_done) else $error("entry did not finish on the third cycle");

  property p_xlate_hold;
    entry_go |=> !XLATE_READY [*2] ##1 XLATE_READY;
  endproperty
  a_xlate_hold: assert property (p_xlate_hold) else $error("translation not held off during entry");

  property p_fetch;
    entry_go |-> ##2 UNCACHED_FETCH;
  endproperty
  a_fetch: assert property (p_fetch) else $error("uncached fields not fetched at entry");

  property p_mask_obey;
    entry_go |-> ##2 ((USE_CACHE & ~$past(ENTRY.reload_mask[11:0], 2)) == 12'h000);
  endproperty
  a_mask_obey: assert property (p_mask_obey) else $error("cached group used against a clear mask bit");

  property p_bad_cmd;
    entry_go |-> ##2 (ENTRY_BAD_CMD == !($past(ENTRY.flush_cmd, 2) inside {8'h00, 8'h01, 8'h03, 8'h07}));
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("flush byte classification wrong");

  property p_guest_tag;
    entry_go |-> ##3 (CUR_TAG == $past(ENTRY.tag, 3));
  endproperty
  a_guest_tag: assert property (p_guest_tag) else $error("guest tag not current after entry");

  property p_host_tag;
    !IN_GUEST |-> (CUR_TAG == 12'h000);
  endproperty
  a_host_tag: assert property (p_host_tag) else $error("host context tag not zero");

  property p_exit;
    (EXIT_REQ && IN_GUEST) |=> (!IN_GUEST && CUR_TAG == 12'h000);
  endproperty
  a_exit: assert property (p_exit) else $error("exit did not return to host context");

  property p_lookup;
    (LOOKUP_REQ && XLATE_READY) |=> LOOKUP_VALID ##1 (LOOKUP_VALID == $past(LOOKUP_REQ && XLATE_READY));
  endproperty
  a_lookup: assert property (p_lookup) else $error("lookup answer missing or too long");

  property p_cap;
    !$past(SYS_RST) |-> CAP_FLUSH_TAG;
  endproperty
  a_cap: assert property (p_cap) else $error("per-tag flush capability not shown");
endmodule // gsct_top_properties

bind gsct_top gsct_top_properties u_props (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .ENTRY_REQ(ENTRY_REQ), .ENTRY(ENTRY), .EXIT_REQ(EXIT_REQ),
  .LOOKUP_REQ(LOOKUP_REQ), .ENTRY_DONE(ENTRY_DONE), .ENTRY_BAD_CMD(ENTRY_BAD_CMD), .USE_CACHE(USE_CACHE),
  .UNCACHED_FETCH(UNCACHED_FETCH), .IN_GUEST(IN_GUEST), .CUR_TAG(CUR_TAG), .XLATE_READY(XLATE_READY),
  .LOOKUP_VALID(LOOKUP_VALID), .CAP_FLUSH_TAG(CAP_FLUSH_TAG)
);

// file: verification/gsct_top_tb_top.sv
// gsct_top_tb_top: self-checking bench for guest entry state caching and tagged flushes.
// assumes the hypervisor model supplies the entry fields; every other input is driven here.
`timescale 1ns/100ps
module gsct_top_tb_top;
  typedef struct packed {
    logic [7:0]  addr;
    logic [11:0] tag;
    logic        fresh;
    logic [11:0] chg;
    logic [7:0]  cmd;
    logic [11:0] use_exp;
    logic        bad;
  } gsct_row_s;

  logic                  clock, sys_rst, hv_go, hv_fresh, exit_req, invpg_req, fill_req, lookup_req;
  logic [51:0]           hv_addr;
  logic [11:0]           hv_tag, hv_chg;
  logic [7:0]            hv_cmd;
  logic [63:0]           invpg_acc;
  logic [31:0]           invpg_cnt;
  logic [35:0]           lookup_vpn;
  logic                  entry_req;
  gsct_pkg::gsct_entry_s entry;
  gsct_pkg::gsct_evt_s   evt;
  gsct_pkg::gsct_fill_s  fill_d;
  logic                  ENTRY_DONE, ENTRY_BAD_CMD, UNCACHED_FETCH, IN_GUEST, XLATE_READY;
  logic                  LOOKUP_VALID, LOOKUP_HIT, CAP_FLUSH_TAG;
  logic [11:0]           USE_CACHE, CUR_TAG;
  logic [39:0]           LOOKUP_PPN;
  int                    n_errors, samples_checked, cycles;

  // fresh block, all-clean with reserved bits set, partly dirty, unknown block, reserved command
  gsct_row_s rows [5] = '{
    '{8'ha1, 12'h005, 1'b1, 12'h000, 8'h00, 12'h000, 1'b0},
    '{8'ha1, 12'h005, 1'b0, 12'h000, 8'h01, 12'hfff, 1'b0},
    '{8'ha1, 12'h005, 1'b0, 12'h021, 8'h03, 12'hfde, 1'b0},
    '{8'hb2, 12'h009, 1'b0, 12'h000, 8'h07, 12'h000, 1'b0},
    '{8'ha1, 12'h005, 1'b0, 12'h000, 8'h02, 12'hfff, 1'b1}};

  gsct_hv_model u_hv (.go(hv_go), .cb_addr(hv_addr), .tag(hv_tag), .fresh(hv_fresh), .changed(hv_chg),
    .cmd(hv_cmd), .entry_req(entry_req), .entry(entry));

  gsct_top uut (.CLOCK(clock), .SYS_RST(sys_rst), .ENTRY_REQ(entry_req), .ENTRY(entry), .EXIT_REQ(exit_req),
    .EVT(evt), .INVPG_REQ(invpg_req), .INVPG_ACC(invpg_acc), .INVPG_CNT(invpg_cnt), .FILL_REQ(fill_req),
    .FILL(fill_d), .LOOKUP_REQ(lookup_req), .LOOKUP_VPN(lookup_vpn), .ENTRY_DONE(ENTRY_DONE),
    .ENTRY_BAD_CMD(ENTRY_BAD_CMD), .USE_CACHE(USE_CACHE), .UNCACHED_FETCH(UNCACHED_FETCH),
    .IN_GUEST(IN_GUEST), .CUR_TAG(CUR_TAG), .XLATE_READY(XLATE_READY), .LOOKUP_VALID(LOOKUP_VALID),
    .LOOKUP_HIT(LOOKUP_HIT), .LOOKUP_PPN(LOOKUP_PPN), .CAP_FLUSH_TAG(CAP_FLUSH_TAG));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic enter(input logic [7:0] a, input logic [11:0] t, input logic f, input logic [11:0] c,
                       input logic [7:0] cmd);
    int n;
    n = 0;
    @(negedge clock);
    {hv_addr, hv_tag, hv_fresh, hv_chg, hv_cmd, hv_go} = {44'h0, a, t, f, c, cmd, 1'b1};
    @(negedge clock);
    hv_go = 1'b0;
    while (ENTRY_DONE !== 1'b1 && n < 8) begin
      @(negedge clock);
      n++;
    end
    check("entry_done", ENTRY_DONE, 1'b1);
  endtask

  task automatic leave();
    @(negedge clock);
    exit_req = 1'b1;
    @(negedge clock);
    exit_req = 1'b0;
    check("host_tag", CUR_TAG, 12'h000);
  endtask

  task automatic fill(input logic [35:0] v, input logic [39:0] p, input logic g);
    @(negedge clock);
    fill_req = 1'b1;
    fill_d = {v, p, g};
    @(negedge clock);
    fill_req = 1'b0;
  endtask

  task automatic look(input logic [35:0] v, input logic h, input logic [39:0] p);
    @(negedge clock);
    lookup_req = 1'b1;
    lookup_vpn = v;
    @(negedge clock);
    lookup_req = 1'b0;
    check("lookup_valid", LOOKUP_VALID, 1'b1);
    check("lookup_hit", LOOKUP_HIT, h);
    if (h)
      check("lookup_ppn", LOOKUP_PPN, p);
  endtask

  task automatic pulse_evt(input logic [9:0] e);
    @(negedge clock);
    evt = e;
    @(negedge clock);
    evt = '0;
  endtask

  task automatic invpg(input logic [35:0] v, input logic [11:0] t);
    @(negedge clock);
    {invpg_req, invpg_acc, invpg_cnt} = {1'b1, 16'h0, v, 12'habc, 20'h00000, t};
    @(negedge clock);
    invpg_req = 1'b0;
  endtask

  initial begin
    cycles = 0;
    while (cycles < 5000) begin
      @(posedge clock);
      cycles++;
    end
    n_errors++;
    print_verdict();
  end

  initial begin
    {sys_rst, hv_go, hv_fresh, exit_req, invpg_req, fill_req, lookup_req} = 7'b1000000;
    {hv_addr, hv_tag, hv_chg, hv_cmd, invpg_acc, invpg_cnt, lookup_vpn} = '0;
    evt = '0;
    fill_d = '0;
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    repeat (2) @(negedge clock);
    check("xlate_ready", XLATE_READY, 1'b1);
    check("cap_flag", CAP_FLUSH_TAG, 1'b1);
    check("reset_tag", CUR_TAG, 12'h000);
    foreach (rows[i]) begin
      enter(rows[i].addr, rows[i].tag, rows[i].fresh, rows[i].chg, rows[i].cmd);
      check("use_cache", USE_CACHE, rows[i].use_exp);
      check("bad_cmd", ENTRY_BAD_CMD, rows[i].bad);
      check("guest_tag", CUR_TAG, rows[i].tag);
      leave();
    end
    fill(36'h1, 40'h11, 1'b1);
    enter(8'ha1, 12'h005, 1'b0, 12'h000, 8'h00);
    look(36'h1, 1'b0, 40'h0);
    fill(36'h2, 40'h22, 1'b0);
    fill(36'h3, 40'h33, 1'b1);
    leave();
    look(36'h1, 1'b1, 40'h11);
    enter(8'ha1, 12'h005, 1'b0, 12'h000, 8'h00);
    look(36'h2, 1'b1, 40'h22);
    pulse_evt(10'h300);
    look(36'h2, 1'b1, 40'h22);
    pulse_evt(10'h100);
    look(36'h2, 1'b0, 40'h0);
    look(36'h3, 1'b1, 40'h33);
    pulse_evt(10'h020);
    look(36'h3, 1'b0, 40'h0);
    fill(36'h2, 40'h22, 1'b0);
    fill(36'h4, 40'h44, 1'b0);
    invpg(36'h4, 12'h009);
    invpg(36'h2, 12'h005);
    look(36'h2, 1'b0, 40'h0);
    look(36'h4, 1'b1, 40'h44);
    leave();
    look(36'h1, 1'b1, 40'h11);
    enter(8'ha1, 12'h005, 1'b0, 12'h000, 8'h03);
    look(36'h4, 1'b0, 40'h0);
    fill(36'h2, 40'h22, 1'b0);
    fill(36'h3, 40'h33, 1'b1);
    leave();
    look(36'h1, 1'b1, 40'h11);
    enter(8'ha1, 12'h005, 1'b0, 12'h000, 8'h07);
    look(36'h3, 1'b1, 40'h33);
    look(36'h2, 1'b0, 40'h0);
    leave();
    enter(8'ha1, 12'h005, 1'b0, 12'h000, 8'h01);
    leave();
    look(36'h1, 1'b0, 40'h0);
    // each system-wide event, raised inside a guest, must also clear the host tag
    for (int i = 0; i < 5; i++) begin
      fill(36'h1, 40'h11, 1'b1);
      enter(8'ha1, 12'h005, 1'b0, 12'h000, 8'h00);
      pulse_evt(10'(1 << i));
      leave();
      look(36'h1, 1'b0, 40'h0);
    end
    enter(8'hb2, 12'h009, 1'b0, 12'h000, 8'h00);
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    repeat (2) @(negedge clock);
    check("reset_guest", IN_GUEST, 1'b0);
    check("reset_tag", CUR_TAG, 12'h000);
    check("cap_flag", CAP_FLUSH_TAG, 1'b1);
    print_verdict();
  end
endmodule // gsct_top_tb_top
